// File: rtl/amp_fault_pkg.sv
// Package with constants and carrier types for the fault protection block
package amp_fault_pkg;
   // Number of half-bridge channels
   localparam int NUM_CH = 4;
   // Clock rate in kHz
   localparam int CLK_KHZ = 100000;
   // Overload escalation time, in microseconds
   localparam int OVERLOAD_TIME_US = 2600;
   // Overload escalation time in clock cycles (rounded down)
   localparam int OVERLOAD_CYCLES = OVERLOAD_TIME_US * (CLK_KHZ / 1000);
   // Width of the per-channel overload timer
   localparam int OVL_CNT_W = 19;
   // Reset value of latched fault state
   localparam logic RST_LATCH = 1'b0;

   // Detector inputs, all active high, taken as synchronous
   typedef struct packed {
      logic gateSupplyLow;       // Any gate_drive_supply below threshold
      logic logicSupplyLow;      // Logic or bridge supply below threshold
      logic analogSupplyLow;     // analog_regulator_supply below threshold
      logic powerOnReset;        // digital_regulator_supply low (POR)
      logic thermalWarnHot;      // Junction above warning level
      logic thermalWarnCool;     // Junction below lower warning level
      logic thermalHot;          // Junction above shutdown level
   } detect_s;

   // Per-channel detector inputs
   typedef struct packed {
      logic [NUM_CH-1:0] bootLow;     // Bootstrap node undervoltage
      logic [NUM_CH-1:0] limitHit;    // Cycle current limit tripped
      logic [NUM_CH-1:0] hardOc;      // Hard latched overcurrent
      logic [NUM_CH-1:0] pwmMissing;  // Input PWM below min frame rate
   } chan_detect_s;

   // Per-channel output drive control
   typedef struct packed {
      logic [NUM_CH-1:0] highZ;       // Whole half-bridge high impedance
      logic [NUM_CH-1:0] highOff;     // High-side switch off
      logic [NUM_CH-1:0] flipState;   // Force flipped output state
   } bridge_ctl_s;

   // Status of both alert pins
   typedef enum logic [2:0] {
      ST_NORMAL = 3'b001,
      ST_WARN = 3'b010,
      ST_ALERT = 3'b100
   } pin_state_e;
endpackage

// File: rtl/amp_fault_protection_reporting.sv
// Fault detection, shutdown and open-drain status reporting
`timescale 1ns/1ps

// Behaviour
// - Supply undervoltage: all bridges Hi-Z, alert low
// - Undervoltage clears itself when supplies recover
// - Power-on reset clears overload state
// - Reset low forces alert pin high
// - Alert and warning are active-low open-drain
// - Every shutdown fault except missing PWM drives alert low
// - Warning low when hot, self-clears, switching continues
// - Alert/warning pair encodes fault class
// - Global fault stops all channels, alert low except all-PWM-missing
// - Latched faults hold until reset toggled
// - Channel fault stops only affected channels
// - Bootstrap low turns off high side, silent
// - Current limit flips state at fs/2, silent until the overload time latches overload
// - Missing PWM: Hi-Z silently, global if all
// - Reset rising edge resumes after latched fault
module amp_fault_protection_reporting #(
   parameter int NUM_CH = amp_fault_pkg::NUM_CH,
   parameter int OVERLOAD_CYCLES = amp_fault_pkg::OVERLOAD_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Device reset pin, active low
   input wire logic reset_n,
   // Fault detectors
   input wire amp_fault_pkg::detect_s det,
   input wire amp_fault_pkg::chan_detect_s chDet,
   // Switch cycle strobe, one pulse per PWM cycle
   input wire logic pwmCycle,
   // Bridge drive control
   output amp_fault_pkg::bridge_ctl_s bridge,
   // Open-drain status pins
   output logic fault_n_o,
   output logic fault_n_oe,
   output logic thermal_warning_n_o,
   output logic thermal_warning_n_oe
);
   // Latched thermal shutdown
   logic thermalOff;
   // Latched per-channel overload shutdown
   logic [NUM_CH-1:0] overloadShutdown;
   // Per-channel limit duration timers
   logic [amp_fault_pkg::OVL_CNT_W-1:0] ovlCnt [NUM_CH];
   // Thermal warning state with hysteresis
   logic warnActive;
   // Flip toggle for current limiting
   logic [NUM_CH-1:0] flipPhase;
   // Pin state machine
   amp_fault_pkg::pin_state_e pinState;
   amp_fault_pkg::pin_state_e next_pinState;
   // Combined conditions
   logic supplyLow;
   logic latchClear;
   logic allPwmMissing;
   logic alertCond;

   // Saturating timer limit, cast to counter width
   localparam logic [amp_fault_pkg::OVL_CNT_W-1:0] OVL_LIMIT =
      amp_fault_pkg::OVL_CNT_W'(OVERLOAD_CYCLES);

   // Self-clearing supply fault, evaluated live
   always_comb begin
      supplyLow = det.gateSupplyLow | det.logicSupplyLow |
                  det.analogSupplyLow | det.powerOnReset;
   end

   // Latched state cleared by reset low or power-on reset
   always_comb begin
      latchClear = ~reset_n | det.powerOnReset;
   end

   // All channels missing PWM makes a global fault
   always_comb begin
      allPwmMissing = &chDet.pwmMissing;
   end

   // Thermal shutdown latch
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         thermalOff <= amp_fault_pkg::RST_LATCH;
      end else if (det.thermalHot) begin
         thermalOff <= 1'b1;
      end else if (latchClear) begin
         thermalOff <= 1'b0;
      end
   end

   // Per-channel limit timers and overload latches
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         overloadShutdown <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            ovlCnt[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (latchClear) begin
               // Reset low or POR clears overload
               ovlCnt[i] <= '0;
               overloadShutdown[i] <= 1'b0;
            end else begin
               // Hard overcurrent or sustained limiting latches
               if (chDet.hardOc[i] || (ovlCnt[i] == OVL_LIMIT)) begin
                  overloadShutdown[i] <= 1'b1;
               end
               // Timer runs while limiting, restarts otherwise
               if (!chDet.limitHit[i]) begin
                  ovlCnt[i] <= '0;
               end else if (ovlCnt[i] != OVL_LIMIT) begin
                  ovlCnt[i] <= ovlCnt[i] + 1'b1;
               end
            end
         end
      end
   end

   // Warning with hysteresis between hot and cool levels
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         warnActive <= 1'b0;
      end else if (det.thermalWarnHot) begin
         warnActive <= 1'b1;
      end else if (det.thermalWarnCool) begin
         warnActive <= 1'b0;
      end
   end

   // Flip phase toggles each PWM cycle while limiting, giving fs/2
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flipPhase <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (!chDet.limitHit[i]) begin
               flipPhase[i] <= 1'b0;
            end else if (pwmCycle) begin
               flipPhase[i] <= ~flipPhase[i];
            end
         end
      end
   end

   // Bridge control: global faults stop all, channel faults one
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bridge.highZ <= '1;
         bridge.highOff <= '0;
         bridge.flipState <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            // Global causes hit every channel
            bridge.highZ[i] <= supplyLow | thermalOff | allPwmMissing |
                               ~reset_n |
                               overloadShutdown[i] |
                               chDet.pwmMissing[i];
         end
         bridge.highOff <= chDet.bootLow;
         bridge.flipState <= chDet.limitHit & flipPhase;
      end
   end

   // Alert condition: any reported shutdown fault
   always_comb begin
      alertCond = supplyLow | thermalOff | (|overloadShutdown);
   end

   // Pin state next value; reset low masks the alert
   always_comb begin
      if (reset_n && alertCond) begin
         next_pinState = amp_fault_pkg::ST_ALERT;
      end else if (warnActive) begin
         next_pinState = amp_fault_pkg::ST_WARN;
      end else begin
         next_pinState = amp_fault_pkg::ST_NORMAL;
      end
   end

   // Pin state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pinState <= amp_fault_pkg::ST_NORMAL;
      end else begin
         pinState <= next_pinState;
      end
   end

   // Open-drain pins: output low always, enable pulls low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fault_n_o <= 1'b0;
         fault_n_oe <= 1'b0;
         thermal_warning_n_o <= 1'b0;
         thermal_warning_n_oe <= 1'b0;
      end else begin
         fault_n_o <= 1'b0;
         thermal_warning_n_o <= 1'b0;
         case (next_pinState)
            amp_fault_pkg::ST_ALERT: begin
               fault_n_oe <= 1'b1;
               thermal_warning_n_oe <= thermalOff | warnActive;
            end
            amp_fault_pkg::ST_WARN: begin
               fault_n_oe <= 1'b0;
               thermal_warning_n_oe <= 1'b1;
            end
            amp_fault_pkg::ST_NORMAL: begin
               fault_n_oe <= 1'b0;
               thermal_warning_n_oe <= 1'b0;
            end
            default: begin
               fault_n_oe <= 1'b0;
               thermal_warning_n_oe <= 1'b0;
            end
         endcase
      end
   end

   // Reset pin low keeps alert released
   a_reset_masks_alert: assert property (
      @(posedge clk_sys) disable iff (rst)
      !reset_n |=> !fault_n_oe)
      else $error("alert pulled low while reset pin low");

   // Supply low pulls alert and tristates bridges next cycle
   a_supply_shutdown: assert property (
      @(posedge clk_sys) disable iff (rst)
      (supplyLow && reset_n) |=> (fault_n_oe && (&bridge.highZ)))
      else $error("supply low did not shut down");

   // Thermal shutdown holds until reset pin goes low or power-on reset
   a_thermal_latch: assert property (
      @(posedge clk_sys) disable iff (rst)
      (thermalOff && reset_n && !det.powerOnReset) |=> thermalOff)
      else $error("thermal shutdown latch dropped");

   // Thermal shutdown shows on both pins
   a_both_pins_low: assert property (
      @(posedge clk_sys) disable iff (rst)
      (thermalOff && reset_n) |=>
         (fault_n_oe && thermal_warning_n_oe))
      else $error("thermal shutdown not reported on both pins");

   // Bootstrap low affects only high side, not alert
   a_boot_silent: assert property (
      @(posedge clk_sys) disable iff (rst)
      (chDet.bootLow[0] && !alertCond) |=>
         (bridge.highOff[0] && !fault_n_oe))
      else $error("bootstrap fault handled wrongly");

   // Single-channel missing PWM leaves another channel running
   a_channel_isolated: assert property (
      @(posedge clk_sys) disable iff (rst)
      (chDet.pwmMissing == NUM_CH'(1) && reset_n && !alertCond) |=>
         (bridge.highZ[0] && !bridge.highZ[1]))
      else $error("channel fault spread to other channels");

   // Hot warning with no fault lowers only the warning pin
   a_warning_only: assert property (
      @(posedge clk_sys) disable iff (rst)
      (det.thermalWarnHot && !alertCond) ##1 !alertCond |=>
         (thermal_warning_n_oe && !fault_n_oe))
      else $error("warning not reported alone");

   // Timer at limit latches overload next cycle
   a_overload_escalate: assert property (
      @(posedge clk_sys) disable iff (rst)
      (ovlCnt[0] == OVL_LIMIT && !latchClear) |=> overloadShutdown[0])
      else $error("sustained limiting did not latch");

   // Power-on reset clears overload state
   a_por_clears: assert property (
      @(posedge clk_sys) disable iff (rst)
      (det.powerOnReset && !chDet.hardOc[0]) |=> !overloadShutdown[0])
      else $error("power-on reset did not clear overload");

   // Latched overload keeps its channel off and alert low
   a_overload_holds: assert property (
      @(posedge clk_sys) disable iff (rst)
      (overloadShutdown[0] && reset_n) |=>
         (fault_n_oe && bridge.highZ[0]))
      else $error("latched overload not held");

   // Current limiting alone does not pull the alert pin until it latches overload
   a_limit_silent: assert property (
      @(posedge clk_sys) disable iff (rst)
      ((|chDet.limitHit) && !alertCond) |=> !fault_n_oe)
      else $error("current limiting reported on alert pin");

   // Missing PWM everywhere stops all bridges without a report
   a_pwm_silent: assert property (
      @(posedge clk_sys) disable iff (rst)
      (allPwmMissing && !alertCond) |=>
         ((&bridge.highZ) && !fault_n_oe))
      else $error("missing PWM handled wrongly");

   // Warning state drives only the warning pin
   a_pin_state_warn: assert property (
      @(posedge clk_sys) disable iff (rst)
      (pinState == amp_fault_pkg::ST_WARN) |->
         (thermal_warning_n_oe && !fault_n_oe))
      else $error("warning state drives wrong pins");
endmodule // amp_fault_protection_reporting

// File: dv/amp_controller_model.sv
// Controller model that owns the reset pin and watches the status pins
`timescale 1ns/1ps
module amp_controller_model #(
   parameter int HOLD_CYC = 30
) (
   // Clock
   input wire logic clk_sys,
   // Status pin levels on the board
   input wire logic faultPin,
   input wire logic warnPin,
   // Bench request to hold reset low
   input wire logic holdLow,
   // Reset pin and volume-down request
   output logic reset_n,
   output logic volumeDown
);
   int sinceFall = HOLD_CYC; // Cycles since alert fall, saturating
   logic faultLast = 1'b1; // Alert level one cycle ago
   logic resetLevel = 1'b0; // Reset pin level, low at power-up
   assign reset_n = resetLevel;
   // Time the alert low period from its falling edge
   always @(posedge clk_sys) begin
      faultLast <= faultPin;
      if (faultLast && !faultPin) begin
         sinceFall <= 0;
      end else if (sinceFall < HOLD_CYC) begin
         sinceFall <= sinceFall + 1;
      end
   end
   // Release reset only when cool and the hold time has run
   always @(posedge clk_sys) begin
      volumeDown <= #1 (warnPin === 1'b0);
      if (holdLow) begin
         resetLevel <= #1 1'b0;
      end else if (warnPin === 1'b1 && sinceFall >= HOLD_CYC) begin
         resetLevel <= #1 1'b1;
      end
   end
endmodule // amp_controller_model

// File: dv/amp_fault_protection_reporting_tb.sv
// Self-checking bench for the fault protection block
`timescale 1ns/1ps
module amp_fault_protection_reporting_tb;
   localparam int OVL = 40; // Shortened overload time
   localparam int HOLD = 30; // Shortened hold after alert fall
   logic clk_sys = 1'b0; // System clock
   logic rst = 1'b1; // Synchronous reset
   logic holdLow = 1'b1; // Controller holds reset low
   logic pwmCycle = 1'b0; // Switch cycle strobe
   amp_fault_pkg::detect_s det = 7'h02; // Detectors, junction cool
   amp_fault_pkg::chan_detect_s chDet = '0; // Channel detectors
   amp_fault_pkg::bridge_ctl_s bridge; // Bridge control
   logic reset_n; // Device reset pin
   logic volumeDown; // Controller reaction
   logic fault_n_o;
   logic fault_n_oe;
   logic thermal_warning_n_o;
   logic thermal_warning_n_oe;
   int badCount = 0;
   int testsRun = 0;
   int cycles = 0;
   // Pull-ups win unless a pin is driven
   wire logic faultPin = fault_n_oe ? fault_n_o : 1'b1;
   wire logic warnPin = thermal_warning_n_oe ? thermal_warning_n_o : 1'b1;

   amp_fault_protection_reporting #(.OVERLOAD_CYCLES(OVL)) uut (
      .clk_sys(clk_sys), .rst(rst), .reset_n(reset_n), .det(det),
      .chDet(chDet), .pwmCycle(pwmCycle), .bridge(bridge),
      .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
      .thermal_warning_n_o(thermal_warning_n_o),
      .thermal_warning_n_oe(thermal_warning_n_oe));
   amp_controller_model #(.HOLD_CYC(HOLD)) ctrl (
      .clk_sys(clk_sys), .faultPin(faultPin), .warnPin(warnPin),
      .holdLow(holdLow), .reset_n(reset_n), .volumeDown(volumeDown));

   // Clock
   always #5 clk_sys = ~clk_sys;
   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         badCount++;
         endOfTest();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic ok, input string msg);
      testsRun++;
      if (ok !== 1'b1) begin
         badCount++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic pins(input logic f, input logic w, input string msg);
      chk(faultPin === f && warnPin === w, msg);
   endtask
   // Toggle the reset pin through the controller
   task automatic restart();
      holdLow = 1'b1;
      tick(3);
      holdLow = 1'b0;
      for (int i = 0; i < HOLD + 20 && reset_n !== 1'b1; i++) tick(1);
      chk(reset_n === 1'b1, "reset pin never released");
      tick(2);
   endtask
   task automatic testSupply();
      for (int i = 3; i <= 6; i++) begin
         det[i] = 1'b1;
         tick(1);
         chk(bridge.highZ === 4'hf, "supply fault bridges");
         pins(1'b0, 1'b1, "supply fault pins");
         chk(fault_n_oe === 1'b1 && fault_n_o === 1'b0, "drive");
         det[i] = 1'b0;
         tick(2);
         chk(bridge.highZ === 4'h0, "supply recovery bridges");
         pins(1'b1, 1'b1, "supply recovery pins");
      end
   endtask
   task automatic testWarn();
      det.thermalWarnHot = 1'b1;
      det.thermalWarnCool = 1'b0;
      tick(2);
      pins(1'b1, 1'b0, "warning pins");
      chk(bridge.highZ === 4'h0, "warning stopped output");
      det.analogSupplyLow = 1'b1;
      tick(1);
      pins(1'b0, 1'b0, "supply fault with warning");
      det.analogSupplyLow = 1'b0;
      det.thermalWarnHot = 1'b0;
      tick(3);
      pins(1'b1, 1'b0, "warning left early");
      chk(thermal_warning_n_o === 1'b0, "warning drive");
      chk(volumeDown === 1'b1, "no volume reaction");
      det.thermalWarnCool = 1'b1;
      tick(2);
      pins(1'b1, 1'b1, "warning stuck");
   endtask
   task automatic testLatch(input logic hot);
      det.thermalHot = hot;
      chDet.hardOc = hot ? 4'h0 : 4'h8;
      tick(1);
      det.thermalHot = 1'b0;
      chDet.hardOc = 4'h0;
      tick(11);
      chk(bridge.highZ === (hot ? 4'hf : 4'h8), "latch bridges");
      pins(1'b0, !hot, "latched pins");
      restart();
      chk(bridge.highZ === 4'h0, "no resume");
      pins(1'b1, 1'b1, "pins after reset toggle");
   endtask
   task automatic testChannel();
      chDet.pwmMissing = 4'h2;
      tick(1);
      chk(bridge.highZ === 4'h2, "one channel off");
      pins(1'b1, 1'b1, "missing pwm reported");
      chDet.pwmMissing = 4'hf;
      tick(1);
      chk(bridge.highZ === 4'hf, "all channels off");
      pins(1'b1, 1'b1, "global missing pwm reported");
      chDet.pwmMissing = 4'h0;
      chDet.bootLow = 4'h4;
      tick(1);
      chk(bridge.highOff === 4'h4 && bridge.highZ === 4'h0, "boot");
      pins(1'b1, 1'b1, "bootstrap reported");
      chDet.bootLow = 4'h0;
      tick(1);
      chk(bridge.highOff === 4'h0, "bootstrap stuck");
   endtask
   task automatic testLimit();
      chDet.limitHit = 4'h1;
      for (int k = 1; k <= 2; k++) begin
         pwmCycle = 1'b1;
         tick(1);
         pwmCycle = 1'b0;
         tick(1);
         chk(bridge.flipState === 4'(k % 2), "flip state");
      end
      pins(1'b1, 1'b1, "limit reported");
      for (int i = 0; i < OVL + 20 && faultPin !== 1'b0; i++) tick(1);
      chk(bridge.highZ === 4'h1 && faultPin === 1'b0, "no escalation");
      chDet.limitHit = 4'h0;
      tick(5);
      pins(1'b0, 1'b1, "overload not held");
      det.powerOnReset = 1'b1;
      tick(1);
      det.powerOnReset = 1'b0;
      tick(3);
      chk(bridge.highZ === 4'h0 && faultPin === 1'b1, "power-on");
   endtask
   task automatic endOfTest();
      $display("Checks %0d, mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      tick(20);
      rst = 1'b0;
      det.gateSupplyLow = 1'b1;
      tick(2);
      chk(faultPin === 1'b1 && bridge.highZ === 4'hf, "mask");
      det.gateSupplyLow = 1'b0;
      restart();
      testSupply();
      testWarn();
      testLatch(1'b1);
      testLatch(1'b0);
      testChannel();
      testLimit();
      endOfTest();
   end
endmodule // amp_fault_protection_reporting_tb
